// file: spdo_pkg.sv
package spdo_pkg;
  // ----------------------------------------------------------------
  // Timing counts in clock cycles of the shared clock.
  // ----------------------------------------------------------------
  localparam int unsigned CPDED_CYC    = 2;   // NOP cycles after CKE falls.
  localparam int unsigned CKE_MIN_CYC  = 3;   // Least CKE pulse width.
  localparam int unsigned XP_CYC       = 3;   // Power-down exit latency.
  localparam int unsigned IHCKE_CYC    = 1;   // Hold after REF/ACT/PRE.
  localparam int unsigned MRW_CYC      = 10;  // Mode register write time.
  localparam int unsigned DQSCK_CYC    = 2;   // Rounded-up tDQSCK(max)/tCK.
  localparam int unsigned WR_CYC       = 6;   // Rounded-up tWR/tCK.
  localparam int unsigned CLK_STABLE_CYC = 2; // Stable clock before exit.
  localparam int unsigned RL_DEF       = 12;  // Read latency.
  localparam int unsigned WL_DEF       = 6;   // Write latency.
  localparam int unsigned BL_DEF       = 8;   // Burst length.
  // ----------------------------------------------------------------
  // Termination field layout and command codes.
  // ----------------------------------------------------------------
  localparam logic [1:0] ODT_FIELD_OFF = 2'h0;
  localparam int unsigned CA_W         = 10;
  localparam logic [2:0] CA_DPD        = 3'h3;  // CA0=1, CA1=1, CA2=0.
  localparam logic [2:0] CA_NOP        = 3'h7;  // CA0..CA2 all high.
  // Controller-side command requests.
  typedef enum logic [3:0] {
    SPDO_CMD_NOP = 4'h0, SPDO_CMD_RD  = 4'h1, SPDO_CMD_RDA = 4'h2,
    SPDO_CMD_WR  = 4'h3, SPDO_CMD_WRA = 4'h4, SPDO_CMD_MRR = 4'h5,
    SPDO_CMD_MRW = 4'h6, SPDO_CMD_ACT = 4'h7, SPDO_CMD_PRE = 4'h8,
    SPDO_CMD_REF = 4'h9
  } spdo_cmd_e;
endpackage

// file: spdo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spdo_if;
  logic            cke;   // Clock enable, active high.
  logic            cs_n;  // Chip select, active low.
  logic [9:0]      ca;    // Command/address bus.
  logic            odt;   // Termination control pin.
  modport ctrl (output cke, output cs_n, output ca, output odt);
  modport dev  (input cke, input cs_n, input ca, input odt);
endinterface
`default_nettype wire

// file: spdo_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pins arriving from outside the clock domain.
module spdo_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // Only the second stage is visible to the rest of the design.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end
  assign o_q = sync_q;
endmodule // spdo_sync
`default_nettype wire

// file: spdo_device.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - CA training forces termination off, ignores pin.
// - Write leveling: DQ off, strobe follows pin.
// - Controller holds pin high during write leveling.
// - Termination per operation: write, read, calibration.
// - Termination needs nonzero field and pin high.
// - Read turn-off at RL-2, on at RL+BL/2.
// - CKE low, CS_n high enters power-down.
// - No CKE low during MRR, MRW, RD, WR.
// - Two NOPs, then receivers off except CKE.
// - CKE low held at least minimum pulse.
// - No refresh in power-down; controller bounds duration (spdo_ctrl sets no limit, it waits for i_exit_req).
// - CKE high exits; CS_n high with it.
// - Controller waits tXP before valid command.
// - Idle versus active power-down classification.
// - Clock stable two cycles before exit.
// - Read to CKE low spacing.
// - Write to CKE low spacing, plus autoprecharge.
// - REF, ACT, PRE to CKE low after tIHCKE.
// - MRR and MRW to CKE low spacing.
// - Deep power-down entry code; contents lost.
// - Deep power-down: two NOPs, receivers off.
// - Deep power-down exit needs re-initialization.
module spdo_device
  import spdo_pkg::*;
#(
  parameter int unsigned RL = RL_DEF,
  parameter int unsigned BL = BL_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  spdo_if.dev             bus,
  input  wire logic [1:0] i_odt_field,    // Termination field of the mode register.
  input  wire logic       i_odt_in_pd,    // Allow termination during power-down.
  input  wire logic       i_ca_training,  // CA training mode active.
  input  wire logic       i_wr_leveling,  // Write leveling mode active.
  input  wire logic       i_zq_cal,       // ZQ calibration in progress.
  input  wire logic       i_dq_cal,       // DQ calibration read in progress.
  input  wire logic       i_rd_start,     // Read or MRR registered this cycle.
  input  wire logic       i_wr_burst,     // Write burst in progress.
  input  wire logic       i_any_row_open, // At least one bank active.
  input  wire logic       i_init_done,    // Initialization sequence completed.
  output logic            o_dq_term,
  output logic            o_dqs_term,
  output logic            o_rx_on,        // Command/address receivers enabled.
  output logic            o_pd,
  output logic            o_pd_active,
  output logic            o_dpd,
  output logic            o_need_init,
  output logic            o_refresh_ok
);
  // ----------------------------------------------------------------
  // Pin synchronisation.
  // ----------------------------------------------------------------
  // All pins pass one shared two-stage synchroniser, so every decode below
  // sees CKE, CS_n, ODT and CA from the same cycle. The price is two cycles
  // of latency on every pin, which the controller end already allows for.
  // Only CA[2:0] are kept; the deep power-down code needs nothing more.
  logic [CA_W+2:0] pins_s;
  spdo_sync #(.W(CA_W + 3)) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({bus.cke, bus.cs_n, bus.odt, bus.ca}),
    .o_q       (pins_s)
  );
  wire       cke_s  = pins_s[CA_W+2];
  wire       cs_n_s = pins_s[CA_W+1];
  wire       odt_s  = pins_s[CA_W];
  wire [2:0] ca_s   = pins_s[2:0];

  // ----------------------------------------------------------------
  // Power state machine.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_ACT = 4'b0001, S_PD = 4'b0010, S_DPD = 4'b0100, S_UNINIT = 4'b1000
  } spdo_state_e;
  spdo_state_e state_q, state_d;
  logic        cke_prev_q;
  logic [1:0]  cpded_q;      // Counts NOP cycles after entry.
  logic        rx_on_q;
  logic        pd_active_q;

  wire cke_fall   = cke_prev_q && !cke_s;
  wire pd_entry   = cke_fall && cs_n_s;
  wire dpd_entry  = cke_fall && !cs_n_s && (ca_s == CA_DPD);
  wire exit_seen  = cke_s;
  wire cpded_done = (cpded_q == 2'(CPDED_CYC));

  // Next-state decode: entry on falling CKE, exit once CKE is seen high.
  // Deep power-down is tested first, though the two decodes never both hold:
  // plain entry needs CS_n high on the CKE edge and deep entry needs it low.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_ACT: begin
        if (dpd_entry) begin
          state_d = S_DPD;
        end else if (pd_entry) begin
          state_d = S_PD;
        end
      end
      S_PD:     if (exit_seen) state_d = S_ACT;
      S_DPD:    if (exit_seen) state_d = S_UNINIT;
      S_UNINIT: if (i_init_done) state_d = S_ACT;
      default:  state_d = S_UNINIT;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= S_UNINIT;
      cke_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cke_prev_q <= cke_s;
    end
  end

  // Receivers go dark only after the NOP window has elapsed, so the CKE
  // path has time to settle; CKE itself is always watched.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cpded_q <= 2'h0;
      rx_on_q <= 1'b1;
    end else if (state_d == S_PD || state_d == S_DPD) begin
      if (!cpded_done) cpded_q <= cpded_q + 2'h1;
      if (cpded_done) rx_on_q <= 1'b0;
    end else begin
      cpded_q <= 2'h0;
      rx_on_q <= 1'b1;
    end
  end

  // Classify power-down at entry from the bank state.
  // The class is frozen at entry; rows cannot open or close while the
  // receivers are dark, so a later change of the bank flag is ignored.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pd_active_q <= 1'b0;
    end else if (state_q == S_ACT && pd_entry && !dpd_entry) begin
      pd_active_q <= i_any_row_open;
    end
  end

  // ----------------------------------------------------------------
  // Read termination window: off from RL-2 until RL+BL/2.
  // ----------------------------------------------------------------
  localparam int unsigned RD_OFF = RL - 2;
  localparam int unsigned RD_ON  = RL + BL / 2;
  logic [7:0] rd_cnt_q;
  logic       rd_busy_q;
  // A new read restarts the window; back-to-back reads extend it.
  // The counter holds the number of edges since the read was registered,
  // so the window opens at edge RL-2 and closes at edge RL+BL/2+1.
  // A read that arrives inside a window simply restarts the count, which
  // turns termination back on until the new count reaches RL-2.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_cnt_q  <= 8'h00;
      rd_busy_q <= 1'b0;
    end else if (i_rd_start) begin
      rd_cnt_q  <= 8'h00;
      rd_busy_q <= 1'b1;
    end else if (rd_busy_q) begin
      rd_cnt_q  <= rd_cnt_q + 8'h01;
      if (rd_cnt_q == 8'(RD_ON)) rd_busy_q <= 1'b0;
    end
  end
  wire rd_block = rd_busy_q && (rd_cnt_q >= 8'(RD_OFF));

  // ----------------------------------------------------------------
  // Termination decode.
  // ----------------------------------------------------------------
  wire field_on  = (i_odt_field != ODT_FIELD_OFF);
  wire base_on   = field_on && odt_s;
  wire pd_block  = (state_q == S_PD) && !i_odt_in_pd;
  wire off_state = (state_q == S_DPD) || (state_q == S_UNINIT);
  wire any_block = i_ca_training || rd_block || i_zq_cal || i_dq_cal
                   || pd_block || off_state;
  // Strobe pair follows the pin in leveling; DQ never terminates there.
  // DQ termination is further limited to write bursts, since the data pins
  // are only ever received during a write.
  assign o_dqs_term = base_on && !any_block;
  assign o_dq_term  = base_on && !any_block && !i_wr_leveling
                      && i_wr_burst;

  // ----------------------------------------------------------------
  // Status outputs.
  // ----------------------------------------------------------------
  // All status flags decode the registered state, so they change only on
  // clock edges and never glitch with the synchronised pins.
  // After deep power-down the array contents are gone, so the device
  // reports that it needs initialization until the sequence completes.
  assign o_rx_on      = rx_on_q;
  assign o_pd         = (state_q == S_PD);
  assign o_pd_active  = pd_active_q && (state_q == S_PD);
  assign o_dpd        = (state_q == S_DPD);
  assign o_need_init  = (state_q == S_UNINIT);
  // No refresh is run while powered down.
  assign o_refresh_ok = (state_q == S_ACT);
endmodule // spdo_device
`default_nettype wire

// file: spdo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Controller end: sequences CKE, CS_n and CA for power-down entry and exit.
module spdo_ctrl
  import spdo_pkg::*;
#(
  parameter int unsigned RL = RL_DEF,
  parameter int unsigned WL = WL_DEF,
  parameter int unsigned BL = BL_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  spdo_if.ctrl            bus,
  input  wire logic       i_cmd_valid,
  input  wire logic [3:0] i_cmd,
  input  wire logic       i_pd_req,     // Enter power-down.
  input  wire logic       i_dpd_req,    // Enter deep power-down.
  input  wire logic       i_exit_req,   // Leave either power-down.
  input  wire logic       i_odt_en,     // Termination enabled in mode register.
  input  wire logic       i_wr_leveling,
  input  wire logic       i_odt_req,
  output logic            o_cmd_ready,
  output logic            o_pd_ready,
  output logic            o_lowpower,
  output logic            o_need_init
);
  typedef enum logic [3:0] {
    C_RUN = 4'b0001, C_LOW = 4'b0010, C_XP = 4'b0100, C_INIT = 4'b1000
  } spdo_cstate_e;
  spdo_cstate_e st_q;
  logic [7:0] hold_q;     // Cycles left before CKE may fall.
  logic [3:0] tmr_q;      // Low/exit timer.
  logic       deep_q;
  logic       cke_q;
  logic       cs_n_q;
  logic [9:0] ca_q;

  localparam int unsigned RD_GAP  = RL + DQSCK_CYC + BL / 2 + 1;
  localparam int unsigned WR_GAP  = WL + 1 + BL / 2 + WR_CYC;
  wire [3:0] cmd = i_cmd;
  // Gap each command imposes before CKE may be registered low.
  wire [7:0] gap =
      (cmd == SPDO_CMD_RD  || cmd == SPDO_CMD_RDA || cmd == SPDO_CMD_MRR) ? 8'(RD_GAP) :
      (cmd == SPDO_CMD_WR)  ? 8'(WR_GAP) :
      (cmd == SPDO_CMD_WRA) ? 8'(WR_GAP + 1) :
      (cmd == SPDO_CMD_MRW) ? 8'(MRW_CYC) :
      (cmd == SPDO_CMD_NOP) ? 8'h00 : 8'(IHCKE_CYC);
  wire go_low   = (i_pd_req || i_dpd_req) && hold_q == 8'h00;
  wire tmr_done = (tmr_q == 4'h0);

  // CKE sequencing; the low phase covers tCPDED NOPs and the minimum pulse.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= C_INIT; hold_q <= 8'h00; tmr_q <= 4'h0; deep_q <= 1'b0;
      cke_q <= 1'b0; cs_n_q <= 1'b1; ca_q <= 10'h000;
    end else begin
      cs_n_q <= 1'b1;
      ca_q   <= {7'h00, CA_NOP};
      if (tmr_q != 4'h0) tmr_q <= tmr_q - 4'h1;
      if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
      unique case (st_q)
        C_RUN: begin
          if (go_low) begin
            st_q   <= C_LOW;
            cke_q  <= 1'b0;
            deep_q <= i_dpd_req;
            cs_n_q <= !i_dpd_req;
            ca_q   <= {7'h00, i_dpd_req ? CA_DPD : CA_NOP};
            tmr_q  <= 4'(CKE_MIN_CYC > CPDED_CYC ? CKE_MIN_CYC : CPDED_CYC);
          end else if (i_cmd_valid && gap > hold_q) begin
            hold_q <= gap;
          end
        end
        C_LOW: if (tmr_done && i_exit_req) begin
          cke_q <= 1'b1;
          st_q  <= deep_q ? C_INIT : C_XP;
          tmr_q <= 4'(deep_q ? CKE_MIN_CYC : XP_CYC);
        end
        C_XP:   if (tmr_done) st_q <= C_RUN;
        C_INIT: begin
          cke_q <= 1'b1;
          if (tmr_done && !i_exit_req) st_q <= C_RUN;
        end
        default: st_q <= C_INIT;
      endcase
    end
  end
  assign bus.cke  = cke_q;
  assign bus.cs_n = cs_n_q;
  assign bus.ca   = ca_q;
  // Keep the pin high throughout leveling when termination is enabled.
  assign bus.odt  = i_odt_req || (i_wr_leveling && i_odt_en);
  assign o_cmd_ready = (st_q == C_RUN) && !go_low;
  assign o_pd_ready  = (st_q == C_RUN) && hold_q == 8'h00;
  assign o_lowpower  = (st_q == C_LOW);
  assign o_need_init = (st_q == C_INIT);
endmodule // spdo_ctrl
`default_nettype wire

// file: spdo_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Pin-level checks across the controller and device ends.
// ----------------------------------------------------------------
module spdo_assertions
  import spdo_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic [9:0] ca,
  input  wire logic       o_pd,
  input  wire logic       o_dpd,
  input  wire logic       o_rx_on,
  input  wire logic       o_dq_term,
  input  wire logic       o_dqs_term
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // The device sees pins through two flops, so entry lands a few edges late.
  pd_entry_a: assert property ($fell(cke) && cs_n |-> ##[2:3] o_pd)
    else $error("power-down not entered after CKE fell");
  dpd_entry_a: assert property ($fell(cke) && !cs_n && ca[2:0] == CA_DPD |-> ##[2:3] o_dpd)
    else $error("deep power-down not entered after entry code");
  nop_pair_a: assert property ($fell(cke) |=> (cs_n || ca[2:0] == CA_NOP) [*2])
    else $error("no two NOPs after CKE fell");
  cke_low_a: assert property ($fell(cke) |-> !cke [*3])
    else $error("CKE low pulse too short");
  cke_high_a: assert property ($rose(cke) |-> cke [*3])
    else $error("CKE high pulse too short");
  exit_cs_a: assert property ($rose(cke) |-> cs_n)
    else $error("chip select not high at exit");
  rx_off_a: assert property ($rose(o_pd || o_dpd) |-> ##[0:4] !o_rx_on)
    else $error("receivers stay on in power-down");
  pd_exit_a: assert property (o_pd && $rose(cke) |-> ##[1:4] !o_pd)
    else $error("power-down not left after CKE rose");
  dpd_term_a: assert property (o_dpd |-> !o_dq_term && !o_dqs_term)
    else $error("termination on in deep power-down");

  // Main scenarios reached.
  cover property ($rose(o_pd));
  cover property ($rose(o_dpd));
  cover property (o_pd ##1 !o_pd);
endmodule // spdo_assertions
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spdo_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, ends under test and checker.
  // ----------------------------------------------------------------
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cmd_valid, pd_req, dpd_req, exit_req, wl, odt_req, catr, zq, dqc;
  logic       rd_start, row_open, init_done, wrb;
  logic [3:0] cmd;
  logic [1:0] field;
  logic       dq_term, dqs_term, rx_on, pd, pd_active, dpd, d_need_init, refresh_ok;
  logic       cmd_ready, pd_ready, lowpower, c_need_init;
  int         err_total = 0;
  int         checked = 0;

  always #25 clk = ~clk;
  spdo_if spdo_if_i ();
  spdo_ctrl spdo_ctrl_i (.i_clk(clk), .i_reset_n(reset_n), .bus(spdo_if_i.ctrl),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_pd_req(pd_req), .i_dpd_req(dpd_req),
    .i_exit_req(exit_req), .i_odt_en(1'b1), .i_wr_leveling(wl), .i_odt_req(odt_req),
    .o_cmd_ready(cmd_ready), .o_pd_ready(pd_ready), .o_lowpower(lowpower),
    .o_need_init(c_need_init));
  // DQ termination also depends on the write burst flag, driven by the bench.
  spdo_device spdo_device_i (.i_clk(clk), .i_reset_n(reset_n), .bus(spdo_if_i.dev),
    .i_odt_field(field), .i_odt_in_pd(1'b0), .i_ca_training(catr), .i_wr_leveling(wl),
    .i_zq_cal(zq), .i_dq_cal(dqc), .i_rd_start(rd_start), .i_wr_burst(wrb),
    .i_any_row_open(row_open), .i_init_done(init_done), .o_dq_term(dq_term),
    .o_dqs_term(dqs_term), .o_rx_on(rx_on), .o_pd(pd), .o_pd_active(pd_active),
    .o_dpd(dpd), .o_need_init(d_need_init), .o_refresh_ok(refresh_ok));
  spdo_assertions spdo_assertions_i (.i_clk(clk), .i_reset_n(reset_n),
    .cke(spdo_if_i.cke), .cs_n(spdo_if_i.cs_n), .ca(spdo_if_i.ca), .o_pd(pd),
    .o_dpd(dpd), .o_rx_on(rx_on), .o_dq_term(dq_term), .o_dqs_term(dqs_term));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Leave power-down and measure the gap until commands are accepted.
  task automatic leave();
    int n;
    exit_req = 1'b1;
    for (n = 0; n < 50 && spdo_if_i.cke !== 1'b1; n++) @(negedge clk);
    exit_req = 1'b0;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
    check(n >= XP_CYC, 1'b1);
    repeat (4) @(negedge clk);
  endtask

  // Bits: field[6:5], pin[4], CA training[3], leveling[2], ZQ[1], DQ cal[0].
  task automatic t_term();
    logic [6:0] tbl [9] = '{7'h30, 7'h50, 7'h70, 7'h20, 7'h10, 7'h38, 7'h34, 7'h32, 7'h31};
    logic       on;
    foreach (tbl[k]) begin
      {field, odt_req, catr, wl, zq, dqc} = tbl[k];
      repeat (4) @(negedge clk);
      on = (tbl[k][6:5] != 2'h0) && tbl[k][4] && ((tbl[k][3:0] & 4'hB) == 4'h0);
      check(dqs_term, on);
      check(dq_term, on && !tbl[k][2]);
      if (tbl[k][2]) check(spdo_if_i.odt, 1'b1);
    end
    {field, odt_req, catr, wl, zq, dqc} = 7'h30;
    wrb = 1'b0;
    repeat (2) @(negedge clk);
    check({dq_term, dqs_term}, 2'h1);
    wrb = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // Termination is cut only inside the read window.
  task automatic t_read();
    rd_start = 1'b1;
    @(negedge clk);
    rd_start = 1'b0;
    repeat (2) @(negedge clk);
    check(dqs_term, 1'b1);
    repeat (RL_DEF - 2) @(negedge clk);
    check({dq_term, dqs_term}, 2'h0);
    repeat (BL_DEF / 2 + 3) @(negedge clk);
    check(dqs_term, 1'b1);
  endtask

  task automatic t_pd(input logic row);
    int n;
    row_open = row;
    for (n = 0; n < 50 && pd_ready !== 1'b1; n++) @(negedge clk);
    pd_req = 1'b1;
    for (n = 0; n < 50 && pd !== 1'b1; n++) @(negedge clk);
    pd_req = 1'b0;
    repeat (4) @(negedge clk);
    check(pd_active, row);
    check(refresh_ok, 1'b0);
    check(rx_on, 1'b0);
    check(lowpower, 1'b1);
    leave();
    check({pd, rx_on}, 2'h1);
  endtask

  // Each command, then an immediate request; CKE must wait the command's gap.
  task automatic t_gaps();
    spdo_cmd_e c [9] = '{SPDO_CMD_RD, SPDO_CMD_RDA, SPDO_CMD_MRR, SPDO_CMD_WR, SPDO_CMD_WRA,
                         SPDO_CMD_MRW, SPDO_CMD_ACT, SPDO_CMD_PRE, SPDO_CMD_REF};
    int rd = RL_DEF + DQSCK_CYC + BL_DEF / 2 + 1;
    int wr = WL_DEF + 1 + BL_DEF / 2 + WR_CYC;
    int g [9] = '{rd, rd, rd, wr, wr + 1, MRW_CYC, IHCKE_CYC, IHCKE_CYC, IHCKE_CYC};
    int n;
    row_open = 1'b0;
    foreach (c[k]) begin
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
      cmd_valid = 1'b1;
      cmd = c[k];
      @(negedge clk);
      cmd_valid = 1'b0;
      pd_req = 1'b1;
      for (n = 1; n < 100 && spdo_if_i.cke !== 1'b0; n++) @(negedge clk);
      check(n >= g[k], 1'b1);
      for (n = 0; n < 50 && pd !== 1'b1; n++) @(negedge clk);
      pd_req = 1'b0;
      leave();
    end
  endtask

  // Deep power-down loses contents: both ends demand initialization after exit.
  task automatic t_dpd();
    int n;
    for (n = 0; n < 50 && pd_ready !== 1'b1; n++) @(negedge clk);
    dpd_req = 1'b1;
    for (n = 0; n < 50 && dpd !== 1'b1; n++) @(negedge clk);
    dpd_req = 1'b0;
    init_done = 1'b0;
    repeat (4) @(negedge clk);
    check({dpd, rx_on}, 2'h2);
    exit_req = 1'b1;
    for (n = 0; n < 50 && spdo_if_i.cke !== 1'b1; n++) @(negedge clk);
    exit_req = 1'b0;
    check(c_need_init, 1'b1);
    repeat (6) @(negedge clk);
    check({dpd, d_need_init, c_need_init}, 3'h2);
    init_done = 1'b1;
    repeat (4) @(negedge clk);
    check(d_need_init, 1'b0);
  endtask

  // Main sequence; inputs change on the falling edge only.
  initial begin
    {cmd_valid, pd_req, dpd_req, exit_req, wl, catr, zq, dqc, rd_start, row_open} = '0;
    {odt_req, init_done, field, cmd} = {1'b1, 1'b1, 2'h1, 4'h0};
    wrb = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_term();
    t_read();
    t_pd(1'b0);
    t_pd(1'b1);
    t_gaps();
    t_dpd();
    test_done();
  end

  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
